// ===== rtl/port_ctrl_map.vh
// register map, field layout and reset constants of the port controller
`ifndef PORT_CTRL_MAP_VH
`define PORT_CTRL_MAP_VH

// register indexes; byte address on the bus is four times the index
`define P0_DATA_IDX   14'h0018
`define P1_DATA_IDX   14'h0019
`define P2_DATA_IDX   14'h001a
`define P3_DATA_IDX   14'h001b
`define P4_DATA_IDX   14'h001c
`define P6_DATA_IDX   14'h001e
`define P7_DATA_IDX   14'h001f
`define P0_DIR_IDX    14'h0020
`define P1_DIR_IDX    14'h0021
`define P2_DIR_IDX    14'h0022
`define P3_DIR_IDX    14'h0023
`define P4_DIR_IDX    14'h0024
`define P6_DIR_IDX    14'h0026
`define P7_DIR_IDX    14'h0027
`define P0_ALT_IDX    14'h0028
`define P1_ALT_IDX    14'h0029
`define P2_ALT_IDX    14'h002a
`define P3_ALT_IDX    14'h002b
`define P4_ALT_IDX    14'h002c
`define P6_ALT_IDX    14'h002e
`define P7_ALT_IDX    14'h002f
`define P8_DATA_IDX   14'h00b8
`define P9_DATA_IDX   14'h00b9
`define P10_DATA_IDX  14'h00ba
`define P12_PIN_IDX   14'h00bc
`define P13_PIN_IDX   14'h00bd
`define P15_DATA_IDX  14'h00bf
`define P8_DIR_IDX    14'h00c0
`define P9_DIR_IDX    14'h00c1
`define P10_DIR_IDX   14'h00c2
`define P15_DIR_IDX   14'h00c5
`define P15_ALT_IDX   14'h00c7
`define P8_ALT_IDX    14'h00c8
`define P9_ALT_IDX    14'h00c9
`define P10_ALT_IDX   14'h00ca
`define P20_DATA_IDX  14'h1b80
`define P21_DATA_IDX  14'h1b81
`define P20_DIR_IDX   14'h1b82
`define P21_DIR_IDX   14'h1b83
`define P20_ALT_IDX   14'h1b84
`define P21_ALT_IDX   14'h1b85

// register kinds returned by the address decoder
`define KIND_DATA     2'h0
`define KIND_DIR      2'h1
`define KIND_ALT      2'h2
`define KIND_PIN      2'h3

// reset values
`define RST_BYTE      8'h00
`define EXT_RST_P014  8'hff
`define EXT_RST_P2    8'h0f
`define EXT_RST_P3    8'h02

// cycles from reset release until the strap is sampled through its synchroniser
`define STRAP_WAIT    2'h2

`endif

// ===== rtl/port_ctrl.v
// general-purpose port controller with apb register access
//
// Chosen here: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "port_ctrl_map.vh"

module port_ctrl #(
  parameter [103:0] ALT_PRESENT = {104{1'b1}}
) (
  input  wire         pclk,
  input  wire         presetn,
  input  wire         psel,
  input  wire         penable,
  input  wire         pwrite,
  input  wire [15:0]  paddr,
  input  wire [31:0]  pwdata,
  input  wire [3:0]   pstrb,
  output wire [31:0]  prdata,
  output wire         pready,
  output wire         pslverr,
  input  wire         ext_memory_strap_n,
  input  wire [103:0] pin_in,
  output wire [103:0] pin_out,
  output wire [103:0] pin_oe,
  output wire [103:0] pin_pullup_en,
  output wire [103:0] alt_in,
  input  wire [103:0] alt_out,
  input  wire [7:0]   analog_shared_input_port,
  input  wire [7:0]   interrupt_input_port,
  output wire [7:0]   analog_shared_in_sync,
  output wire [7:0]   interrupt_input_sync
);

  // slots 0-12 hold ports 0,1,2,3,4,6,7,8,9,10,15,20,21
  localparam NSLOT = 13;

  // ==========================================================
  // address decode
  // ==========================================================
  // returns {hit, kind[1:0], slot[3:0]}
  function [6:0] decode;
    input [13:0] idx;
    begin
      // data registers of all thirteen slots
      if (idx == `P0_DATA_IDX)
        decode = {1'b1, `KIND_DATA, 4'h0};
      else if (idx == `P1_DATA_IDX)
        decode = {1'b1, `KIND_DATA, 4'h1};
      else if (idx == `P2_DATA_IDX)
        decode = {1'b1, `KIND_DATA, 4'h2};
      else if (idx == `P3_DATA_IDX)
        decode = {1'b1, `KIND_DATA, 4'h3};
      else if (idx == `P4_DATA_IDX)
        decode = {1'b1, `KIND_DATA, 4'h4};
      else if (idx == `P6_DATA_IDX)
        decode = {1'b1, `KIND_DATA, 4'h5};
      else if (idx == `P7_DATA_IDX)
        decode = {1'b1, `KIND_DATA, 4'h6};
      else if (idx == `P8_DATA_IDX)
        decode = {1'b1, `KIND_DATA, 4'h7};
      else if (idx == `P9_DATA_IDX)
        decode = {1'b1, `KIND_DATA, 4'h8};
      else if (idx == `P10_DATA_IDX)
        decode = {1'b1, `KIND_DATA, 4'h9};
      else if (idx == `P15_DATA_IDX)
        decode = {1'b1, `KIND_DATA, 4'ha};
      else if (idx == `P20_DATA_IDX)
        decode = {1'b1, `KIND_DATA, 4'hb};
      else if (idx == `P21_DATA_IDX)
        decode = {1'b1, `KIND_DATA, 4'hc};
      // direction registers
      else if (idx == `P0_DIR_IDX)
        decode = {1'b1, `KIND_DIR, 4'h0};
      else if (idx == `P1_DIR_IDX)
        decode = {1'b1, `KIND_DIR, 4'h1};
      else if (idx == `P2_DIR_IDX)
        decode = {1'b1, `KIND_DIR, 4'h2};
      else if (idx == `P3_DIR_IDX)
        decode = {1'b1, `KIND_DIR, 4'h3};
      else if (idx == `P4_DIR_IDX)
        decode = {1'b1, `KIND_DIR, 4'h4};
      else if (idx == `P6_DIR_IDX)
        decode = {1'b1, `KIND_DIR, 4'h5};
      else if (idx == `P7_DIR_IDX)
        decode = {1'b1, `KIND_DIR, 4'h6};
      else if (idx == `P8_DIR_IDX)
        decode = {1'b1, `KIND_DIR, 4'h7};
      else if (idx == `P9_DIR_IDX)
        decode = {1'b1, `KIND_DIR, 4'h8};
      else if (idx == `P10_DIR_IDX)
        decode = {1'b1, `KIND_DIR, 4'h9};
      else if (idx == `P15_DIR_IDX)
        decode = {1'b1, `KIND_DIR, 4'ha};
      else if (idx == `P20_DIR_IDX)
        decode = {1'b1, `KIND_DIR, 4'hb};
      else if (idx == `P21_DIR_IDX)
        decode = {1'b1, `KIND_DIR, 4'hc};
      // alt-select registers; ports 12 and 13 have none, as they hold no slot
      else if (idx == `P0_ALT_IDX)
        decode = {1'b1, `KIND_ALT, 4'h0};
      else if (idx == `P1_ALT_IDX)
        decode = {1'b1, `KIND_ALT, 4'h1};
      else if (idx == `P2_ALT_IDX)
        decode = {1'b1, `KIND_ALT, 4'h2};
      else if (idx == `P3_ALT_IDX)
        decode = {1'b1, `KIND_ALT, 4'h3};
      else if (idx == `P4_ALT_IDX)
        decode = {1'b1, `KIND_ALT, 4'h4};
      else if (idx == `P6_ALT_IDX)
        decode = {1'b1, `KIND_ALT, 4'h5};
      else if (idx == `P7_ALT_IDX)
        decode = {1'b1, `KIND_ALT, 4'h6};
      else if (idx == `P8_ALT_IDX)
        decode = {1'b1, `KIND_ALT, 4'h7};
      else if (idx == `P9_ALT_IDX)
        decode = {1'b1, `KIND_ALT, 4'h8};
      else if (idx == `P10_ALT_IDX)
        decode = {1'b1, `KIND_ALT, 4'h9};
      else if (idx == `P15_ALT_IDX)
        decode = {1'b1, `KIND_ALT, 4'ha};
      else if (idx == `P20_ALT_IDX)
        decode = {1'b1, `KIND_ALT, 4'hb};
      else if (idx == `P21_ALT_IDX)
        decode = {1'b1, `KIND_ALT, 4'hc};
      // read-only pin views of the input-only ports
      else if (idx == `P12_PIN_IDX)
        decode = {1'b1, `KIND_PIN, 4'h0};
      else if (idx == `P13_PIN_IDX)
        decode = {1'b1, `KIND_PIN, 4'h1};
      // anything else answers with an error
      else
        decode = 7'h00;
    end
  endfunction

  // strap-dependent reset value of slots 0-4 when the strap is low
  function [7:0] ext_reset;
    input [3:0] slot;
    begin
      if (slot == 4'h2)
        ext_reset = `EXT_RST_P2;
      else if (slot == 4'h3)
        ext_reset = `EXT_RST_P3;
      else
        ext_reset = `EXT_RST_P014;
    end
  endfunction

  // ==========================================================
  // state
  // ==========================================================
  reg  [7:0]   data_q [0:NSLOT-1];
  reg  [7:0]   dir_q  [0:NSLOT-1];
  reg  [7:0]   alt_q  [0:NSLOT-1];
  reg  [119:0] in_meta_q;
  reg  [119:0] in_sync_q;
  reg          strap_meta_q;
  reg          strap_sync_q;
  reg  [1:0]   init_cnt_q;
  reg          init_done_q;
  reg          ack_q;
  reg          err_q;
  reg  [7:0]   rdata_q;
  reg  [7:0]   rdata_d;
  wire [6:0]   dec;
  wire [3:0]   slot;
  wire [1:0]   kind;
  wire         access;
  wire         wr_fire;
  wire [103:0] dir_flat;
  wire [103:0] alt_flat;
  wire [103:0] data_flat;
  wire [103:0] sec_out;
  wire [103:0] read_view;
  integer      i;

  assign dec    = decode(paddr[15:2]);
  assign slot   = dec[3:0];
  assign kind   = dec[5:4];
  assign access = psel & penable & init_done_q;
  assign wr_fire = access & ack_q & pwrite & pstrb[0];

  // ==========================================================
  // pin synchronisers and strap capture
  // ==========================================================
  // every pin passes two flops before any logic reads it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_meta_q    <= 120'h0;
      in_sync_q    <= 120'h0;
      strap_meta_q <= 1'b1;
      strap_sync_q <= 1'b1;
    end else begin
      in_meta_q    <= {interrupt_input_port, analog_shared_input_port, pin_in};
      in_sync_q    <= in_meta_q;
      strap_meta_q <= ext_memory_strap_n;
      strap_sync_q <= strap_meta_q;
    end
  end

  // waits for the strap to settle through its synchroniser, then releases the bus
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_cnt_q  <= 2'h0;
      init_done_q <= 1'b0;
    end else if (!init_done_q) begin
      init_cnt_q <= init_cnt_q + 2'h1;
      if (init_cnt_q == `STRAP_WAIT)
        init_done_q <= 1'b1;
    end
  end

  // ==========================================================
  // port registers
  // ==========================================================
  // reset to zero, strap load after release, then byte writes from the bus
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < NSLOT; i = i + 1) begin
        data_q[i] <= `RST_BYTE;
        dir_q[i]  <= `RST_BYTE;
        alt_q[i]  <= `RST_BYTE;
      end
    end else if (!init_done_q) begin
      if (init_cnt_q == `STRAP_WAIT) begin
        for (i = 0; i < 5; i = i + 1) begin
          // strap high keeps zero, strap low loads the external-memory value
          dir_q[i] <= strap_sync_q ? `RST_BYTE : ext_reset(i[3:0]);
          alt_q[i] <= strap_sync_q ? `RST_BYTE : ext_reset(i[3:0]);
        end
      end
    end else if (wr_fire && dec[6]) begin
      // pin-state kind holds no storage, so those writes fall through
      if (kind == `KIND_DATA)
        data_q[slot] <= pwdata[7:0];
      else if (kind == `KIND_DIR)
        dir_q[slot] <= pwdata[7:0];
      else if (kind == `KIND_ALT)
        alt_q[slot] <= pwdata[7:0];
    end
  end

  // ==========================================================
  // pin drive
  // ==========================================================
  genvar g;
  generate
    for (g = 0; g < NSLOT; g = g + 1) begin : slot_gen
      assign dir_flat[8*g +: 8]  = dir_q[g];
      assign alt_flat[8*g +: 8]  = alt_q[g];
      assign data_flat[8*g +: 8] = data_q[g];
    end
  endgenerate

  // unassigned secondary functions read and drive zero
  assign sec_out       = alt_out & ALT_PRESENT;
  // output enable on dir; alt picks secondary over stored data
  assign pin_oe        = dir_flat;
  assign pin_out       = (alt_flat & sec_out) | (~alt_flat & data_flat);
  assign pin_pullup_en = ~dir_flat & alt_flat;
  // secondary inputs see the pin regardless of alt-select
  assign alt_in        = in_sync_q[103:0];
  assign analog_shared_in_sync = in_sync_q[111:104];
  assign interrupt_input_sync  = in_sync_q[119:112];

  // per-bit read view: pin when input, else stored or secondary output
  assign read_view = (~dir_flat & in_sync_q[103:0]) | (dir_flat & pin_out);

  // ==========================================================
  // apb slave
  // ==========================================================
  // read mux
  always @* begin
    rdata_d = 8'h00;
    if (dec[6]) begin
      if (kind == `KIND_DATA)
        rdata_d = read_view[8*slot +: 8];
      else if (kind == `KIND_DIR)
        rdata_d = dir_q[slot];
      else if (kind == `KIND_ALT)
        rdata_d = alt_q[slot];
      else if (slot == 4'h0)
        rdata_d = in_sync_q[111:104];
      else
        rdata_d = in_sync_q[119:112];
    end
  end

  // one wait state: the first access cycle registers the answer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_q   <= 1'b0;
      err_q   <= 1'b0;
      rdata_q <= 8'h00;
    end else if (access && !ack_q) begin
      ack_q   <= 1'b1;
      err_q   <= ~dec[6];
      rdata_q <= pwrite ? 8'h00 : rdata_d;
    end else begin
      ack_q <= 1'b0;
      err_q <= 1'b0;
    end
  end

  assign pready  = ack_q;
  assign pslverr = ack_q & err_q;
  assign prdata  = {24'h000000, rdata_q};

endmodule
`default_nettype wire

// ===== verif/port_ctrl_asserts.sv
// checker of the port controller apb answer, reset images and pin relations
`timescale 1ns/100ps
`default_nettype none
module port_ctrl_asserts #(
  parameter [103:0] ALT_PRESENT = {104{1'b1}}
) (
  input wire logic         pclk,
  input wire logic         presetn,
  input wire logic         psel,
  input wire logic         penable,
  input wire logic [31:0]  prdata,
  input wire logic         pready,
  input wire logic         pslverr,
  input wire logic         ext_memory_strap_n,
  input wire logic [103:0] pin_in,
  input wire logic [103:0] pin_out,
  input wire logic [103:0] pin_oe,
  input wire logic [103:0] pin_pullup_en,
  input wire logic [103:0] alt_in,
  input wire logic [103:0] alt_out,
  input wire logic [7:0]   interrupt_input_port,
  input wire logic [7:0]   interrupt_input_sync,
  input wire logic [7:0]   analog_shared_input_port,
  input wire logic [7:0]   analog_shared_in_sync
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ports 4..0 image loaded when the strap selects external memory
  localparam [39:0] LOW_IMG = 40'hff_02_0f_ff_ff;
  // ==========================================================
  // apb answer
  sequence s_wait;
    psel && penable && !pready;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  AST_ONE_WAIT: assert property (s_wait |-> ##[1:8] s_answer)
    else $error("access not answered by a one cycle ready");
  AST_READY_CAUSE: assert property (pready |-> psel && penable && $past(psel && penable))
    else $error("ready without a held access");
  AST_ERR_PAIRS: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error response malformed");
  AST_BYTE_WIDE: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("read data wider than a byte");
  // ==========================================================
  // reset images and pins
  AST_DIR_RESET: assert property ($rose(presetn) |-> ##3 pin_oe ==
    {64'h0, ext_memory_strap_n ? 40'h0 : LOW_IMG})
    else $error("direction reset image wrong");
  AST_ALT_RESET: assert property ($rose(presetn) |-> ##3 pin_out ==
    {64'h0, ext_memory_strap_n ? 40'h0 : alt_out[39:0] & ALT_PRESENT[39:0] & LOW_IMG})
    else $error("alternate select reset image wrong");
  AST_PULLUP_INPUT: assert property (!(|(pin_pullup_en & pin_oe)))
    else $error("pull-up on a driven pin");
  AST_ALT_IN_SYNC: assert property ($past(presetn, 2) |-> alt_in == $past(pin_in, 2))
    else $error("secondary input not two cycles behind pin");
  AST_IRQ_SYNC: assert property ($past(presetn, 2) |->
    interrupt_input_sync == $past(interrupt_input_port, 2))
    else $error("input-only port not two cycles behind pin");
  AST_ANALOG_SYNC: assert property ($past(presetn, 2) |->
    analog_shared_in_sync == $past(analog_shared_input_port, 2))
    else $error("analog-shared port not two cycles behind pin");
endmodule
bind port_ctrl port_ctrl_asserts #(.ALT_PRESENT(ALT_PRESENT)) port_ctrl_asserts_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .ext_memory_strap_n(ext_memory_strap_n),
  .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en),
  .alt_in(alt_in), .alt_out(alt_out), .interrupt_input_port(interrupt_input_port),
  .interrupt_input_sync(interrupt_input_sync),
  .analog_shared_input_port(analog_shared_input_port),
  .analog_shared_in_sync(analog_shared_in_sync));
`default_nettype wire

// ===== verif/pin_world.sv
// external pins and secondary-function sources around the port controller
`timescale 1ns/100ps
`default_nettype none
module pin_world (
  input  wire logic [103:0] pin_out,
  input  wire logic [103:0] pin_oe,
  input  wire logic [103:0] pin_pullup_en,
  input  wire logic [103:0] ext_level,
  input  wire logic [103:0] sec_level,
  input  wire logic [15:0]  io_level,
  output logic      [103:0] pin_in,
  output logic      [103:0] alt_out,
  output logic      [7:0]   analog_shared_input_port,
  output logic      [7:0]   interrupt_input_port
);
  // driven pins read back, pulled-up inputs sit high, others follow the outside
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & (pin_pullup_en | ext_level));
  // secondary outputs and the two input-only ports
  assign alt_out = sec_level;
  assign analog_shared_input_port = io_level[7:0];
  assign interrupt_input_port = io_level[15:8];
endmodule
`default_nettype wire

// ===== verif/tb_port_ctrl.sv
// self-checking bench for the port controller register map
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin err_count++; \
  $display("Error %s expected %h seen %h", n, e, s); end end
module tb_port_ctrl;
  logic         pclk, presetn, psel, penable, pwrite, strap_n, er;
  logic [15:0]  paddr, io;
  logic [31:0]  pwdata, prdata;
  logic         pready, pslverr;
  logic [103:0] pin_in, pin_out, pin_oe, pull_en, alt_in, alt_out, ext, sec;
  logic [7:0]   an_p, irq_p, rd, r, a, d, e, s;
  int           err_count, tests_run, seed, k;
  logic [13:0]  dix[13] = '{14'h18, 14'h19, 14'h1a, 14'h1b, 14'h1c, 14'h1e, 14'h1f,
                          14'hb8, 14'hb9, 14'hba, 14'hbf, 14'h1b80, 14'h1b81};
  logic [13:0]  bad[4] = '{14'h25, 14'hc4, 14'hcc, 14'h1b86};

  port_ctrl port_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'h1), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_memory_strap_n(strap_n), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_en(pull_en), .alt_in(alt_in),
    .alt_out(alt_out), .analog_shared_input_port(an_p), .interrupt_input_port(irq_p),
    .analog_shared_in_sync(), .interrupt_input_sync());
  pin_world pin_world_i (.pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_en(pull_en),
    .ext_level(ext), .sec_level(sec), .io_level(io), .pin_in(pin_in), .alt_out(alt_out),
    .analog_shared_input_port(an_p), .interrupt_input_port(irq_p));

  // ==========================================================
  // helpers
  always #4 pclk = ~pclk;
  function automatic logic [13:0] didx(int i);
    return dix[i] + (i < 10 ? 14'h8 : (i == 10 ? 14'h6 : 14'h2));
  endfunction
  function automatic logic [13:0] aidx(int i);
    return dix[i] + (i < 10 ? 14'h10 : (i == 10 ? 14'h8 : 14'h4));
  endfunction
  function automatic logic [7:0] rv(int i);
    return i == 2 ? 8'h0f : (i == 3 ? 8'h02 : (i < 5 ? 8'hff : 8'h00));
  endfunction
  function automatic logic [7:0] expd(logic [7:0] dr, al, dt, sc, ex);
    return (dr & ~al & dt) | (dr & al & sc) | (~dr & (al | ex));
  endfunction
  // one apb transfer, request held until ready is seen at an edge
  task automatic apb(input logic w, input logic [13:0] ix, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= {ix, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata[7:0];
    er = pslverr;
    psel <= 0;
    penable <= 0;
    if (n >= 20) err_count++;
  endtask
  task automatic rchk(input string n, input logic [13:0] ix, input logic [7:0] x);
    apb(0, ix, 8'h00);
    `CHK(n, x, rd)
  endtask
  task automatic do_reset(input logic sv);
    strap_n <= sv;
    presetn <= 0;
    repeat (16) @(posedge pclk);
    presetn <= 1;
    repeat (6) @(posedge pclk);
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ==========================================================
  // watchdog
  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    close_out;
  end

  // ==========================================================
  // main sequence
  initial begin
    {pclk, presetn, psel, penable, pwrite, strap_n} = 6'h01;
    {paddr, pwdata, io, ext, sec} = '0;
    seed = 55;
    err_count = 0;
    tests_run = 0;
    // reset images under both strap levels, strap low first
    for (int sv = 0; sv < 2; sv++) begin
      do_reset(sv[0]);
      for (k = 0; k < 13; k++) begin
        rchk("dir", didx(k), sv ? 8'h00 : rv(k));
        rchk("alt", aidx(k), sv ? 8'h00 : rv(k));
      end
    end
    // per port: data reset, stored data, then random mode decode
    for (k = 0; k < 13; k++) begin
      {r, a, d, e, s} = {$random(seed), 8'h00};
      s = 8'($random(seed));
      ext[8*k +: 8] <= e;
      sec[8*k +: 8] <= s;
      apb(1, didx(k), 8'hff);
      rchk("data0", dix[k], 8'h00);
      apb(1, dix[k], r);
      rchk("data", dix[k], r);
      apb(1, aidx(k), a);
      apb(1, didx(k), d);
      repeat (3) @(posedge pclk);
      rchk("mix", dix[k], expd(d, a, r, s, e));
      rchk("dirrb", didx(k), d);
      rchk("altrb", aidx(k), a);
      `CHK("oe", d, pin_oe[8*k +: 8])
      `CHK("pull", ~d & a, pull_en[8*k +: 8])
      `CHK("pin", (d & ~a & r) | (d & a & s), pin_out[8*k +: 8] & d)
    end
    // input-only ports ignore writes
    io <= 16'($random(seed));
    repeat (3) @(posedge pclk);
    apb(1, 14'hbc, ~io[7:0]);
    `CHK("roerr", 1'b0, er)
    rchk("p12", 14'hbc, io[7:0]);
    apb(1, 14'hbd, ~io[15:8]);
    rchk("p13", 14'hbd, io[15:8]);
    // unmapped places answer with an error
    for (k = 0; k < 4; k++) begin
      apb(k[0], bad[k], 8'h5a);
      `CHK("unmapped", 1'b1, er)
    end
    close_out;
  end
endmodule
`default_nettype wire
